// ---- include/spi_port_regs.vh ----
`ifndef SPI_PORT_REGS_VH
`define SPI_PORT_REGS_VH

// ----------------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------------
`define ADDR_SERIAL_CLOCK_DIVIDER 8'ha2
`define ADDR_SERIAL_DATA_BUFFER 8'ha3
`define RST_SERIAL_CLOCK_DIVIDER 8'h00
`define RST_SERIAL_DATA_BUFFER 8'h00

// ----------------------------------------------------------------------
// Timing: core clock period in ns, the rest in core clock periods, and derived cycle counts
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define EDGES_PER_BYTE 5'h10
`define SLH_MIN_PERIODS 6
`define SLH_MAX_PERIODS 8
`define SLH_DELAY_CYCLES 4'h7
`define BITS_PER_BYTE 4'h8

`endif

// ---- src/spi_pair_buffer.v ----
`default_nettype none

// Two-entry buffer holding received bytes until the receive buffer takes them.
module spi_pair_buffer (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Filling side.
    input wire in_valid,
    output wire in_ready,
    input wire [7:0] in_data,
    // Draining side.
    output wire out_valid,
    input wire out_ready,
    output wire [7:0] out_data
);

    reg [7:0] mem_r [0:1];
    reg wr_ptr_r;
    reg rd_ptr_r;
    reg [1:0] count_r;
    wire push;
    wire pop;

    // Honest full and empty from the occupancy count.
    assign in_ready = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Each entry is written only when the write pointer selects it.
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_entry
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_r[i] <= 8'h00;
                end else if (push && (wr_ptr_r == i)) begin
                    mem_r[i] <= in_data;
                end
            end
        end
    endgenerate

    // Pointers and count advance on accepted pushes and pops.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push && !pop) begin
                count_r <= count_r + 2'h1;
            end else if (pop && !push) begin
                count_r <= count_r - 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- src/spi_port.v ----
`include "spi_port_regs.vh"
`default_nettype none

// Functional notes
// - Master serial clock is core clock over two times divider value plus one.
// - Data write loads transmit buffer; in master mode it starts a transfer.
// - Data read returns the receive buffer, never the transmit buffer.
// - Polarity select high inverts the whole serial clock waveform.
// - Slave drives output within four periods of select low, releases within four.
// - Slave output changes within four periods after each shift edge.
// - Slave with phase one changes output six to eight periods after last edge.
// - Transfer-done flag sets at each byte end and stays until cleared.
// - Write while buffer not empty is dropped and sets write-collision flag.
// - Buffer-empty clears on write, sets when byte moves to shift register.
// - Slave sets overrun when unread byte remains as a new byte completes.
module spi_port (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Special function register bus.
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    // Control bits held in the control register outside.
    input wire port_enable,
    input wire master_mode,
    input wire clock_polarity_select,
    input wire clock_phase_select,
    // Flag clears, one-cycle pulses.
    input wire clr_transfer_done,
    input wire clr_write_collision,
    input wire clr_receive_overrun,
    // Flags.
    output reg tx_buffer_empty_flag,
    output reg transfer_done_flag,
    output reg write_collision_flag,
    output reg receive_overrun_flag,
    // Serial pins.
    input wire slave_select_n,
    input wire sck_in,
    output reg sck_out,
    output reg sck_oe,
    input wire mosi_in,
    output reg mosi_out,
    output reg mosi_oe,
    input wire miso_in,
    output reg miso_out,
    output reg miso_oe
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;

    reg [1:0] state_r;
    reg [7:0] divider_value_r;
    reg [7:0] div_lat_r;
    reg [7:0] half_cnt_r;
    reg [4:0] edge_cnt_r;
    reg phase_r;
    reg [7:0] tx_buf_r;
    reg [7:0] tx_sh_r;
    reg [7:0] rx_sh_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] rx_hold_r;
    reg rx_full_r;
    reg push_r;
    reg [7:0] push_data_r;
    reg sck_prev_r;
    reg [3:0] slh_cnt_r;
    reg tx_loaded_r;

    wire slave_active = port_enable && !master_mode && !slave_select_n;
    wire master_on = port_enable && master_mode;
    wire eff_sck = sck_in ^ clock_polarity_select;
    wire eff_prev = sck_prev_r ^ clock_polarity_select;
    wire slv_lead = slave_active && eff_sck && !eff_prev;
    wire slv_trail = slave_active && !eff_sck && eff_prev;
    wire mst_tick = (state_r == ST_RUN) && (half_cnt_r == 8'h00);
    wire mst_lead = mst_tick && !phase_r;
    wire mst_trail = mst_tick && phase_r;
    wire lead_ev = master_on ? mst_lead : slv_lead;
    wire trail_ev = master_on ? mst_trail : slv_trail;
    wire sample_ev = clock_phase_select ? trail_ev : lead_ev;
    wire shift_ev = clock_phase_select ? lead_ev : trail_ev;
    wire in_bit = master_on ? miso_in : mosi_in;
    wire [7:0] rx_next = {rx_sh_r[6:0], in_bit};
    wire mst_end = mst_tick && (edge_cnt_r == `EDGES_PER_BYTE - 5'h01);
    wire slv_end = sample_ev && !master_on && (bit_cnt_r == `BITS_PER_BYTE - 4'h1);
    wire byte_end = mst_end || slv_end;
    wire buf_ready;
    wire buf_valid;
    wire [7:0] buf_data;
    wire wr_div = sfr_wr && (sfr_addr == `ADDR_SERIAL_CLOCK_DIVIDER);
    wire wr_dat = sfr_wr && (sfr_addr == `ADDR_SERIAL_DATA_BUFFER);
    wire rd_dat = sfr_rd && (sfr_addr == `ADDR_SERIAL_DATA_BUFFER);
    wire hold_take = buf_valid && (!rx_full_r || rd_dat);
    wire mst_start = master_on && (state_r == ST_IDLE) && !tx_buffer_empty_flag && buf_ready;
    wire slv_load = !master_on && !tx_buffer_empty_flag && (bit_cnt_r == 4'h0)
                    && !tx_loaded_r;
    wire tx_move = mst_start || slv_load;

    // ------------------------------------------------------------------
    // Received bytes wait here; a full buffer holds off master starts.
    // ------------------------------------------------------------------
    spi_pair_buffer u_rx_buffer (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push_r),
        .in_ready(buf_ready),
        .in_data(push_data_r),
        .out_valid(buf_valid),
        .out_ready(!rx_full_r || rd_dat),
        .out_data(buf_data)
    );

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    // Divider register and registered read data; unmapped addresses read zero.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divider_value_r <= `RST_SERIAL_CLOCK_DIVIDER;
            sfr_rdata <= 8'h00;
        end else begin
            if (wr_div) begin
                divider_value_r <= sfr_wdata;
            end
            if (sfr_addr == `ADDR_SERIAL_CLOCK_DIVIDER) begin
                sfr_rdata <= divider_value_r;
            end else if (sfr_addr == `ADDR_SERIAL_DATA_BUFFER) begin
                sfr_rdata <= rx_hold_r;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

    // Transmit buffer with empty and collision flags; a set beats a clear.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_buf_r <= `RST_SERIAL_DATA_BUFFER;
            tx_buffer_empty_flag <= 1'b1;
            write_collision_flag <= 1'b0;
        end else begin
            if (wr_dat && tx_buffer_empty_flag) begin
                tx_buf_r <= sfr_wdata;
                tx_buffer_empty_flag <= 1'b0;
            end else if (tx_move) begin
                tx_buffer_empty_flag <= 1'b1;
            end
            if (wr_dat && !tx_buffer_empty_flag) begin
                write_collision_flag <= 1'b1;
            end else if (clr_write_collision) begin
                write_collision_flag <= 1'b0;
            end
        end
    end

    // Receive buffer and the done and overrun flags; a set beats a clear.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_hold_r <= `RST_SERIAL_DATA_BUFFER;
            rx_full_r <= 1'b0;
            transfer_done_flag <= 1'b0;
            receive_overrun_flag <= 1'b0;
        end else begin
            if (hold_take) begin
                rx_hold_r <= buf_data;
                rx_full_r <= 1'b1;
            end else if (rd_dat) begin
                rx_full_r <= 1'b0;
            end
            if (byte_end) begin
                transfer_done_flag <= 1'b1;
            end else if (clr_transfer_done) begin
                transfer_done_flag <= 1'b0;
            end
            if (slv_end && (rx_full_r || buf_valid || !buf_ready)) begin
                receive_overrun_flag <= 1'b1;
            end else if (clr_receive_overrun) begin
                receive_overrun_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Master clock generator
    // ------------------------------------------------------------------
    // Each half period lasts divider plus one core cycles, latched at start.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            div_lat_r <= 8'h00;
            half_cnt_r <= 8'h00;
            edge_cnt_r <= 5'h00;
            phase_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    phase_r <= 1'b0;
                    edge_cnt_r <= 5'h00;
                    if (mst_start) begin
                        div_lat_r <= divider_value_r;
                        half_cnt_r <= divider_value_r;
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!master_on) begin
                        state_r <= ST_IDLE;
                    end else if (mst_tick) begin
                        half_cnt_r <= div_lat_r;
                        phase_r <= ~phase_r;
                        edge_cnt_r <= edge_cnt_r + 5'h01;
                        if (mst_end) begin
                            state_r <= ST_IDLE;
                        end
                    end else begin
                        half_cnt_r <= half_cnt_r - 8'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Shift engine shared by master and slave
    // ------------------------------------------------------------------
    // Bytes move MSB first; output bit changes on shift edges.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_r <= 8'h00;
            rx_sh_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            mosi_out <= 1'b0;
            miso_out <= 1'b0;
            push_r <= 1'b0;
            push_data_r <= 8'h00;
            sck_prev_r <= 1'b0;
            slh_cnt_r <= 4'h0;
            tx_loaded_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_in;
            push_r <= byte_end && buf_ready;
            if (byte_end) begin
                push_data_r <= sample_ev ? rx_next : rx_sh_r;
            end
            if (!master_on && slave_select_n) begin
                bit_cnt_r <= 4'h0;
                tx_loaded_r <= 1'b0;
            end else if (sample_ev) begin
                rx_sh_r <= rx_next;
                bit_cnt_r <= slv_end ? 4'h0 : bit_cnt_r + 4'h1;
                tx_loaded_r <= slv_end ? 1'b0 : tx_loaded_r;
            end
            if (tx_move) begin
                tx_loaded_r <= 1'b1;
                if (clock_phase_select) begin
                    tx_sh_r <= tx_buf_r;
                end else begin
                    tx_sh_r <= {tx_buf_r[6:0], 1'b0};
                    mosi_out <= tx_buf_r[7];
                    miso_out <= tx_buf_r[7];
                end
            end else if (shift_ev) begin
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                mosi_out <= tx_sh_r[7];
                miso_out <= tx_sh_r[7];
            end
            // Phase one slave: release the last bit a fixed delay after the end.
            if (slv_end && clock_phase_select) begin
                slh_cnt_r <= `SLH_DELAY_CYCLES;
            end else if (slh_cnt_r != 4'h0) begin
                slh_cnt_r <= slh_cnt_r - 4'h1;
                if (slh_cnt_r == 4'h1) begin
                    miso_out <= tx_sh_r[7];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Clock idles at the polarity level and is inverted as a whole.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            mosi_oe <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            sck_out <= clock_polarity_select ^ (master_on && state_r == ST_RUN && phase_r);
            sck_oe <= master_on;
            mosi_oe <= master_on;
            miso_oe <= slave_active;
        end
    end

endmodule

`default_nettype wire

// ---- test/spi_port_properties.sv ----
`include "spi_port_regs.vh"
`default_nettype none
// Watches the port pins for clock rate, flag and slave enable timing.
module spi_port_properties (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register bus and control.
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic port_enable,
    input wire logic master_mode,
    input wire logic clock_polarity_select,
    input wire logic clr_transfer_done,
    // Flags and pins.
    input wire logic tx_buffer_empty_flag,
    input wire logic transfer_done_flag,
    input wire logic write_collision_flag,
    input wire logic slave_select_n,
    input wire logic sck_out,
    input wire logic miso_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sck_q_r;
    logic [1:0] up_r;
    logic [3:0] tcnt_r;
    logic [9:0] gap_r;
    logic [7:0] div_r;
    logic [7:0] div_use_r;
    logic tog;
    logic dat_wr;
    // A master clock toggle once reset has settled, and a data register write.
    assign tog = master_mode && up_r == 2'h3 && sck_out != sck_q_r;
    assign dat_wr = sfr_wr && sfr_addr == `ADDR_SERIAL_DATA_BUFFER;
    // Counts toggles and their spacing; the divider is taken as each byte starts.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q_r <= 1'b0;
            up_r <= 2'h0;
            tcnt_r <= 4'h0;
            gap_r <= 10'h000;
            div_r <= 8'h00;
            div_use_r <= 8'h00;
        end else begin
            sck_q_r <= sck_out;
            up_r <= up_r + {1'b0, up_r != 2'h3};
            gap_r <= tog ? 10'h001 : gap_r + {9'h000, gap_r != 10'h3ff};
            if (sfr_wr && sfr_addr == `ADDR_SERIAL_CLOCK_DIVIDER) begin
                div_r <= sfr_wdata;
            end
            if (tog) begin
                tcnt_r <= tcnt_r + 4'h1;
            end
            if (tog && tcnt_r == 4'h0) begin
                div_use_r <= div_r;
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    rate_match_a: assert property (
        tog && tcnt_r != 4'h0 |-> gap_r == {2'h0, div_use_r} + 10'h001)
        else $error("half period differs from divider");
    idle_level_a: assert property (
        master_mode && up_r == 2'h3 && tcnt_r == 4'h0 && !tog |-> sck_out == clock_polarity_select)
        else $error("idle clock level wrong");
    start_sck_a: assert property (
        master_mode && dat_wr && tx_buffer_empty_flag |-> ##[1:300] tog)
        else $error("write did not start clock");
    buf_clear_a: assert property (dat_wr && tx_buffer_empty_flag |=> !tx_buffer_empty_flag)
        else $error("empty flag not cleared");
    collision_set_a: assert property (dat_wr && !tx_buffer_empty_flag |=> write_collision_flag)
        else $error("collision flag not set");
    done_set_a: assert property (tog && tcnt_r == 4'hf |-> ##[0:2] transfer_done_flag)
        else $error("done flag late");
    done_hold_a: assert property (
        transfer_done_flag && !clr_transfer_done |=> transfer_done_flag)
        else $error("done flag dropped");
    miso_drive_a: assert property (
        !master_mode && port_enable && $fell(slave_select_n) |-> ##[1:4] miso_oe)
        else $error("slave output not driven");
    miso_release_a: assert property (
        !master_mode && $rose(slave_select_n) |-> ##[1:4] !miso_oe)
        else $error("slave output not released");
endmodule
`default_nettype wire

// ---- test/spi_peer.sv ----
`default_nettype none
// Far-side device: a slave while the port masters, a master otherwise.
module spi_peer (
    // Clock and mode.
    input wire logic clk,
    input wire logic dev_master,
    input wire logic pol,
    input wire logic pha,
    // Resolved lines.
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    // Lines driven here.
    output logic ss_n,
    output logic sck_m,
    output logic mosi_m,
    output logic miso_s
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] tx_r = 8'h00;
    logic [7:0] rx_r = 8'h00;
    logic sck_q_r = 1'b0;
    logic miso_q_r = 1'b0;
    // Idle master lines; the clock stands still outside frames.
    initial begin
        ss_n = 1'b1;
        sck_m = 1'b0;
        mosi_m = 1'b0;
    end
    // A released line shows the inverse of its last level, so stale data never matches.
    assign miso_s = dev_master ? tx_r[7] : ~miso_q_r;
    // Slave role: capture on the leading edge, shift out on the trailing edge.
    always @(posedge clk) begin
        sck_q_r <= sck;
        miso_q_r <= miso;
        if (dev_master && sck != sck_q_r && sck != pol) begin
            rx_r <= {rx_r[6:0], mosi};
        end
        if (dev_master && sck != sck_q_r && sck == pol) begin
            tx_r <= {tx_r[6:0], ~tx_r[0]};
        end
    end
    // Sets the byte the slave role sends next.
    task automatic load(input logic [7:0] b);
        tx_r = b;
    endtask
    // Master role: phase zero samples four cycles after each data change, phase one five cycles after the leading edge.
    task automatic mxfer(input logic [7:0] tx, output logic [7:0] rx);
        @(posedge clk);
        ss_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi_m <= tx[i];
            repeat (4) @(posedge clk);
            if (!pha) begin
                rx[i] = miso;
            end
            @(posedge clk);
            sck_m <= ~pol;
            repeat (5) @(posedge clk);
            if (pha) begin
                rx[i] = miso;
            end
            sck_m <= pol;
            repeat (5) @(posedge clk);
        end
        ss_n <= 1'b1;
        mosi_m <= ~tx[0];
    endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`include "spi_port_regs.vh"
`default_nettype none
// Drives the register bus and checks the port against the far-side model.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ckr_addr = `ADDR_SERIAL_CLOCK_DIVIDER;
    localparam logic [7:0] dat_addr = `ADDR_SERIAL_DATA_BUFFER;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic master_mode = 1'b1;
    logic pol = 1'b0;
    logic pha = 1'b0;
    logic [2:0] clr = 3'h0;
    logic [7:0] v;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    wire [7:0] sfr_rdata;
    wire empty_f, done_f, write_collision_flag_f, ovr_f, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    wire ss_n, sck_m, mosi_m, miso_s;
    // Each line carries whichever party has its enable up.
    wire sck = sck_oe ? sck_out : sck_m;
    wire mosi = mosi_oe ? mosi_out : mosi_m;
    wire miso = miso_oe ? miso_out : miso_s;
    spi_port u_spi_port (
        .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .port_enable(1'b1),
        .master_mode(master_mode), .clock_polarity_select(pol), .clock_phase_select(pha),
        .clr_transfer_done(clr[0]), .clr_write_collision(clr[1]), .clr_receive_overrun(clr[2]),
        .tx_buffer_empty_flag(empty_f), .transfer_done_flag(done_f),
        .write_collision_flag(write_collision_flag_f), .receive_overrun_flag(ovr_f), .slave_select_n(ss_n),
        .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso), .miso_out(miso_out), .miso_oe(miso_oe)
    );
    spi_peer u_spi_peer (
        .clk(clk), .dev_master(master_mode), .pol(pol), .sck(sck), .mosi(mosi), .miso(miso),
        .pha(pha), .ss_n(ss_n), .sck_m(sck_m), .mosi_m(mosi_m), .miso_s(miso_s)
    );
    // Core clock and a ceiling on run length.
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            finish_test();
        end
    end
    // Comparison, bus cycles and flag clearing.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(negedge clk);
        chk(what, e, sfr_rdata);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        clr[i] <= 1'b1;
        @(posedge clk);
        clr[i] <= 1'b0;
        @(negedge clk);
    endtask
    task automatic wait_done();
        for (int i = 0; i < 400 && done_f !== 1'b1; i++) @(posedge clk);
        @(negedge clk);
        chk("done flag", 8'h01, done_f);
        pulse(0);
    endtask
    task automatic reset(input logic m, input logic p, input logic h);
        @(posedge clk);
        rst_n <= 1'b0;
        master_mode <= m;
        pol <= p;
        pha <= h;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Register, master, polarity and slave tests in turn.
    initial begin
        reset(1'b1, 1'b0, 1'b0);
        rc(ckr_addr, 8'h00, "divider reset");
        rc(dat_addr, 8'h00, "data reset");
        wr(ckr_addr, 8'h03);
        rc(ckr_addr, 8'h03, "divider readback");
        rc(8'h10, 8'h00, "unmapped read");
        $display("register test done");
        u_spi_peer.load(8'h96);
        @(posedge clk);
        sfr_addr <= dat_addr;
        sfr_wdata <= 8'h5a;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wdata <= 8'h33;
        @(posedge clk);
        sfr_wr <= 1'b0;
        @(negedge clk);
        chk("collision flag", 8'h01, write_collision_flag_f);
        repeat (8) @(posedge clk);
        wr(ckr_addr, 8'h05);
        wait_done();
        chk("peer byte", 8'h5a, u_spi_peer.rx_r);
        chk("buffer empty", 8'h01, empty_f);
        rc(dat_addr, 8'h96, "master rx");
        u_spi_peer.load(8'h4b);
        wr(dat_addr, 8'hc3);
        wait_done();
        chk("peer byte 2", 8'hc3, u_spi_peer.rx_r);
        rc(dat_addr, 8'h4b, "master rx 2");
        pulse(1);
        chk("collision clear", 8'h00, write_collision_flag_f);
        $display("master test done");
        reset(1'b1, 1'b1, 1'b0);
        u_spi_peer.load(8'he7);
        wr(ckr_addr, 8'h02);
        wr(dat_addr, 8'h81);
        wait_done();
        chk("idle clock", 8'h01, sck_out);
        chk("peer byte 3", 8'h81, u_spi_peer.rx_r);
        rc(dat_addr, 8'he7, "inverted rx");
        $display("polarity test done");
        reset(1'b0, 1'b0, 1'b0);
        wr(dat_addr, 8'h3c);
        u_spi_peer.mxfer(8'hc5, v);
        chk("slave tx", 8'h3c, v);
        wait_done();
        u_spi_peer.mxfer(8'h0f, v);
        @(negedge clk);
        chk("overrun flag", 8'h01, ovr_f);
        rc(dat_addr, 8'hc5, "slave rx");
        pulse(2);
        chk("overrun clear", 8'h00, ovr_f);
        $display("slave test done");
        reset(1'b0, 1'b0, 1'b1);
        wr(dat_addr, 8'ha5);
        u_spi_peer.mxfer(8'h3e, v);
        @(negedge clk);
        chk("slave hold early", 8'h01, miso_out);
        repeat (3) @(negedge clk);
        chk("slave hold late", 8'h00, miso_out);
        chk("phase one tx", 8'ha5, v);
        wait_done();
        rc(dat_addr, 8'h3e, "phase one rx");
        $display("phase test done");
        finish_test();
    end
endmodule
bind spi_port spi_port_properties u_spi_port_properties (.*);
`default_nettype wire
